// >>> core/crc_pkg.sv
// constants, types and helpers of the clock control block
// assumes a single 125 MHz clock; oscillator waveforms arrive as sampled levels
package crc_pkg;

  // ==========================================================================
  // timing
  localparam int CRC_CLOCK_PERIOD_NS = 8;
  localparam int CRC_PLL_IN_MHZ      = 4;
  localparam int CRC_PLL_OUT_MHZ     = 96;
  localparam int CRC_FAST_OSC_MHZ    = 8;
  localparam logic [15:0] CRC_CLOCK_OUT_EDGES = 16'h0004; // oscillator divided by 4
  localparam logic [15:0] CRC_POST_LONG_EDGES = 16'h0100; // 8 MHz / 256 near 31 kHz

  // ==========================================================================
  // register map: the reference offset is a word index
  localparam logic [11:0] CRC_REF_CTRL_INDEX = 12'hf3d;
  localparam logic [13:0] CRC_REF_CTRL_ADDR  = {CRC_REF_CTRL_INDEX, 2'b00};
  localparam logic [13:0] CRC_TUNE_ADDR      = 14'h0000;
  localparam logic [13:0] CRC_OSC_CTRL_ADDR  = 14'h0004;
  localparam logic [13:0] CRC_CONFIG_ADDR    = 14'h0008;

  // ==========================================================================
  // reset values
  localparam logic [7:0] CRC_REF_CTRL_RESET = 8'h00;
  localparam logic [7:0] CRC_TUNE_RESET     = 8'h00;
  localparam logic [7:0] CRC_OSC_CTRL_RESET = 8'h70; // fast oscillator direct
  localparam logic [7:0] CRC_CONFIG_RESET   = 8'h00; // external clock, prescale 1, cpu 1
  localparam logic [7:0] CRC_REF_CTRL_MASK  = 8'hbf; // bit 6 unimplemented

  // ==========================================================================
  // field positions
  localparam int CRC_REF_EN_BIT     = 7;
  localparam int CRC_REF_SLEEP_BIT  = 5;
  localparam int CRC_REF_SRC_BIT    = 4;
  localparam int CRC_REF_DIV_LSB    = 0;
  localparam int CRC_TUNE_MULT_BIT  = 6;
  localparam int CRC_FREQ_SEL_LSB   = 4;
  localparam int CRC_POST_LONG_BIT  = 0;
  localparam int CRC_MODE_LSB       = 0;
  localparam int CRC_PRE_LSB        = 3;
  localparam int CRC_CPU_LSB        = 6;
  localparam logic [2:0] CRC_FREQ_SLOW = 3'h0;
  localparam logic [2:0] CRC_FREQ_FAST = 3'h7;

  // ==========================================================================
  // oscillator modes, in clock_config field order
  typedef enum logic [2:0] {
    external_clock_mode,
    external_clock_with_multiplier,
    crystal_fast_mode,
    crystal_with_multiplier,
    internal_fast,
    internal_fast_with_multiplier,
    internal_fast_with_multiplier_out,
    internal_slow
  } crc_mode_t;

  // cpu divider code to edges per toggle: 1, 2, 3 or 6
  function automatic logic [15:0] crc_cpu_edges(input logic [1:0] code);
    case (code)
      2'h0:    return 16'h0001;
      2'h1:    return 16'h0002;
      2'h2:    return 16'h0003;
      default: return 16'h0006;
    endcase
  endfunction : crc_cpu_edges

  // toggle divider step: toggling every n edges of a source divides it by n
  function automatic logic [16:0] crc_div_step(input logic [15:0] cnt, input logic lvl,
                                               input logic hit, input logic [15:0] edges);
    if (!hit) begin
      return {lvl, cnt};
    end
    if (cnt >= edges - 16'h0001) begin
      return {~lvl, 16'h0000};
    end
    return {lvl, cnt + 16'h0001};
  endfunction : crc_div_step

endpackage : crc_pkg

// >>> core/crc_clock_control.sv
// clock source selection, multiplier dividers, clock out pin and reference clock output
// assumes oscillator levels sampled on clock, well below 62 MHz
// How it works
// - external mode: clock out is oscillator/4
// - external multiplier mode: clock out is multiplier/4
// - external modes insert no start-up delay
// - multiplier runs in four modes when enabled
// - multiplier makes 96 MHz from 4 MHz
// - input prescaler has eight integer ratios
// - cpu divider after multiplier: 1,2,3,6
// - fast oscillator direct or through postscaler
// - fast oscillator with multiplier reaches 48 MHz
// - slow oscillator runs when selected or needed
// - frequency select picks fast, slow or postscaler
// - enable bit drives reference clock on pin
// - divider field selects power-of-two division
// - source bit picks crystal or system clock
// - sleep-run bit keeps reference during sleep with crystal source
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module crc_clock_control #(
  parameter int STARTUP_EDGES = 1024
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire logic [13:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // oscillator waveforms
  input  wire logic        clock_in_pin,
  input  wire logic        fast_internal_osc,
  input  wire logic        slow_internal_rc,
  input  wire logic        multiplier_clock,
  // device state
  input  wire logic        sleep_active,
  input  wire logic        power_up_timer_enable,
  input  wire logic        fail_safe_enable,
  input  wire logic        watchdog_enable,
  input  wire logic        two_speed_enable,
  // clock outputs
  output logic             clock_out_pin,
  output logic             clock_out_oe,
  output logic             multiplier_run,
  output logic             multiplier_ref_clock,
  output logic             usb_clock,
  output logic             system_clock,
  output logic             slow_rc_enable,
  output logic             startup_done,
  // reference output pin
  output logic             refout_port_pin,
  output logic             refout_port_oe
);

  // ==========================================================================
  // elaboration checks
  initial begin
    if (STARTUP_EDGES < 1 || STARTUP_EDGES > 65535) begin
      $error("STARTUP_EDGES must lie in 1..65535");
    end
  end

  localparam logic [15:0] START_EDGES = 16'(STARTUP_EDGES);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]  reference_clock_control;
    logic [7:0]  oscillator_tuning_register;
    logic [7:0]  oscillator_control_register;
    logic [7:0]  clock_config;
    logic [7:0]  rdata;
    logic        osc_prev;
    logic        fast_prev;
    logic        mult_prev;
    logic        sys_prev;
    logic        sleep_prev;
    logic [15:0] out_cnt;
    logic        clock_out;
    logic [15:0] pre_cnt;
    logic        pll_ref;
    logic [15:0] cpu_cnt;
    logic        cpu_clk;
    logic [15:0] post_cnt;
    logic        post_clk;
    logic        sys_clk;
    logic        usb_clk;
    logic [15:0] ref_cnt;
    logic        ref_lvl;
    logic [3:0]  ref_div_act;
    logic        ref_src_act;
    logic [15:0] start_cnt;
    logic        start_done;
  } crc_state_t;

  crc_state_t s;
  crc_state_t n;

  // decoded mode
  crc_pkg::crc_mode_t mode;
  logic        mult_mode;
  logic        mult_on;
  logic        ext_mode;
  logic        xtal_mode;
  logic        int_mode;
  logic [2:0]  freq_sel;

  // source edges
  logic        osc_edge;
  logic        fast_edge;
  logic        mult_edge;
  logic        sys_edge;
  logic        pre_src;
  logic        pre_edge;

  // reference output
  logic        ref_base_edge;
  logic        ref_run;
  logic        ref_toggle;

  // scratch
  logic        src_lvl;
  logic [15:0] post_edges;
  logic [16:0] step;

  // ==========================================================================
  // mode decode and source edges
  always_comb begin
    mode      = crc_pkg::crc_mode_t'(s.clock_config[crc_pkg::CRC_MODE_LSB +: 3]);
    ext_mode  = (mode == crc_pkg::external_clock_mode) ||
                (mode == crc_pkg::external_clock_with_multiplier);
    xtal_mode = (mode == crc_pkg::crystal_fast_mode) ||
                (mode == crc_pkg::crystal_with_multiplier);
    int_mode  = (mode == crc_pkg::internal_fast) ||
                (mode == crc_pkg::internal_slow);
    mult_mode = (mode == crc_pkg::external_clock_with_multiplier) ||
                (mode == crc_pkg::crystal_with_multiplier) ||
                (mode == crc_pkg::internal_fast_with_multiplier) ||
                (mode == crc_pkg::internal_fast_with_multiplier_out);
    mult_on   = mult_mode &&
                s.oscillator_tuning_register[crc_pkg::CRC_TUNE_MULT_BIT];
    freq_sel  = s.oscillator_control_register[crc_pkg::CRC_FREQ_SEL_LSB +: 3];

    osc_edge  = clock_in_pin != s.osc_prev;
    fast_edge = fast_internal_osc != s.fast_prev;
    mult_edge = mult_on && (multiplier_clock != s.mult_prev);
    sys_edge  = s.sys_clk != s.sys_prev;

    // internal multiplier modes feed the prescaler from the 8 MHz oscillator
    pre_src   = (mode == crc_pkg::internal_fast_with_multiplier) ||
                (mode == crc_pkg::internal_fast_with_multiplier_out);
    pre_edge  = pre_src ? fast_edge : osc_edge;
    // postscaler: codes 1..6 give 8 MHz / 64 .. / 2; long bit gives the 31 kHz tap
    if (freq_sel == crc_pkg::CRC_FREQ_SLOW) begin
      post_edges = crc_pkg::CRC_POST_LONG_EDGES;
    end else begin
      post_edges = 16'h0001 << (3'h7 - freq_sel);
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    n = s;
    n.osc_prev   = clock_in_pin;
    n.fast_prev  = fast_internal_osc;
    n.mult_prev  = multiplier_clock;
    n.sleep_prev = sleep_active;
    n.sys_prev   = s.sys_clk;

    step         = 17'h00000;
    src_lvl      = 1'b0;

    // register writes; the reference control drops its unimplemented bit
    if (reg_write) begin
      if (reg_addr == crc_pkg::CRC_REF_CTRL_ADDR) begin
        n.reference_clock_control = reg_wdata & crc_pkg::CRC_REF_CTRL_MASK;
      end else if (reg_addr == crc_pkg::CRC_TUNE_ADDR) begin
        n.oscillator_tuning_register = reg_wdata;
      end else if (reg_addr == crc_pkg::CRC_OSC_CTRL_ADDR) begin
        n.oscillator_control_register = reg_wdata;
      end else if (reg_addr == crc_pkg::CRC_CONFIG_ADDR) begin
        n.clock_config = reg_wdata;
      end
    end

    // read data lasts one cycle; unmapped reads zero
    n.rdata = 8'h00;
    if (reg_read) begin
      if (reg_addr == crc_pkg::CRC_REF_CTRL_ADDR) begin
        n.rdata = s.reference_clock_control;
      end else if (reg_addr == crc_pkg::CRC_TUNE_ADDR) begin
        n.rdata = s.oscillator_tuning_register;
      end else if (reg_addr == crc_pkg::CRC_OSC_CTRL_ADDR) begin
        n.rdata = s.oscillator_control_register;
      end else if (reg_addr == crc_pkg::CRC_CONFIG_ADDR) begin
        n.rdata = s.clock_config;
      end
    end

    // prescaler brings n x 4 MHz down to 4 MHz
    step = crc_pkg::crc_div_step(s.pre_cnt, s.pll_ref, pre_edge && mult_on,
             {13'h0000, s.clock_config[crc_pkg::CRC_PRE_LSB +: 3]} + 16'h0001);
    n.pll_ref = step[16] && mult_on;
    n.pre_cnt = step[15:0];

    // multiplier feeds usb directly, the core via the cpu divider
    n.usb_clk = mult_on ? multiplier_clock : 1'b0;

    step = crc_pkg::crc_div_step(s.cpu_cnt, s.cpu_clk, mult_edge,
             crc_pkg::crc_cpu_edges(s.clock_config[crc_pkg::CRC_CPU_LSB +: 2]));
    n.cpu_clk = step[16];
    n.cpu_cnt = step[15:0];


    // fast oscillator postscaler
    step = crc_pkg::crc_div_step(s.post_cnt, s.post_clk, fast_edge, post_edges);
    n.post_clk = step[16];
    n.post_cnt = step[15:0];


    // system clock source; held still while the device sleeps
    if (mult_on) begin
      src_lvl = s.cpu_clk;
    end else if (ext_mode || xtal_mode) begin
      src_lvl = clock_in_pin;
    end else if (mode == crc_pkg::internal_slow) begin
      src_lvl = slow_internal_rc;
    end else if (int_mode) begin
      if (freq_sel == crc_pkg::CRC_FREQ_FAST) begin
        src_lvl = fast_internal_osc;
      end else if (freq_sel == crc_pkg::CRC_FREQ_SLOW &&
                   !s.oscillator_control_register[crc_pkg::CRC_POST_LONG_BIT]) begin
        src_lvl = slow_internal_rc;
      end else begin
        src_lvl = s.post_clk;
      end
    end else begin
      src_lvl = fast_internal_osc; // multiplier mode with multiplier off
    end

    if (!sleep_active) begin
      n.sys_clk = src_lvl;
    end

    // clock out pin: oscillator or multiplier divided by 4
    if (mult_on && mode == crc_pkg::external_clock_with_multiplier) begin
      step = crc_pkg::crc_div_step(s.out_cnt, s.clock_out, mult_edge,
                                   crc_pkg::CRC_CLOCK_OUT_EDGES);
    end else begin
      step = crc_pkg::crc_div_step(s.out_cnt, s.clock_out, osc_edge && ext_mode,
                                   crc_pkg::CRC_CLOCK_OUT_EDGES);
    end

    n.clock_out = step[16];
    n.out_cnt   = step[15:0];

    // start-up: crystal modes wait after waking, external and internal do not
    if (s.sleep_prev && !sleep_active && xtal_mode) begin
      n.start_done = 1'b0;
      n.start_cnt  = 16'h0000;
    end else if (!xtal_mode) begin
      n.start_done = 1'b1;
    end else if (!s.start_done && osc_edge) begin
      n.start_cnt = s.start_cnt + 16'h0001;
      if (s.start_cnt >= START_EDGES - 16'h0001) begin
        n.start_done = 1'b1;
      end
    end

    // reference divider; shadow controls load as the output toggles low or while it is stopped
    step = crc_pkg::crc_div_step(s.ref_cnt, s.ref_lvl, ref_base_edge && ref_run,
                                 16'h0001 << s.ref_div_act);
    if (!ref_run) begin
      n.ref_lvl = 1'b0;
      n.ref_cnt = 16'h0000;
    end else begin
      n.ref_lvl = step[16];
      n.ref_cnt = step[15:0];
    end

    if (!n.ref_lvl && (ref_toggle || !ref_run)) begin
      n.ref_div_act = s.reference_clock_control[crc_pkg::CRC_REF_DIV_LSB +: 4];
      n.ref_src_act = s.reference_clock_control[crc_pkg::CRC_REF_SRC_BIT];
      n.ref_cnt     = 16'h0000;
    end
  end

  // ==========================================================================
  // reference output gating
  always_comb begin
    // crystal source counts oscillator edges, else system edges
    ref_base_edge = s.ref_src_act ? osc_edge : sys_edge;

    // in sleep only sleep-run with crystal source keeps it running
    ref_run = s.reference_clock_control[crc_pkg::CRC_REF_EN_BIT] &&
              (!sleep_active ||
               (s.reference_clock_control[crc_pkg::CRC_REF_SLEEP_BIT] &&
                s.ref_src_act));

    ref_toggle = ref_run && ref_base_edge &&
                 (s.ref_cnt >= (16'h0001 << s.ref_div_act) - 16'h0001);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '{reference_clock_control:    crc_pkg::CRC_REF_CTRL_RESET,
             oscillator_tuning_register: crc_pkg::CRC_TUNE_RESET,
             oscillator_control_register: crc_pkg::CRC_OSC_CTRL_RESET,
             clock_config:               crc_pkg::CRC_CONFIG_RESET,
             start_done:                 1'b1,
             default:                    '0};
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata            = s.rdata;
  assign clock_out_pin        = s.clock_out;
  assign clock_out_oe         = ext_mode; // crystal modes leave the pin to the crystal
  assign multiplier_run       = mult_on;
  assign multiplier_ref_clock = s.pll_ref;
  assign usb_clock            = s.usb_clk;
  assign system_clock         = s.sys_clk;
  assign startup_done         = s.start_done;
  assign refout_port_pin      = s.ref_lvl;
  assign refout_port_oe       = s.reference_clock_control[crc_pkg::CRC_REF_EN_BIT];

  // slow oscillator also serves the timers and monitors that need it
  assign slow_rc_enable = (mode == crc_pkg::internal_slow) ||
                          (int_mode && freq_sel == crc_pkg::CRC_FREQ_SLOW) ||
                          power_up_timer_enable || fail_safe_enable ||
                          watchdog_enable || two_speed_enable;

endmodule : crc_clock_control

`default_nettype wire

// >>> tb/crc_cc_properties.sv
// checker for the clock control ports
// assumes it is bound to crc_clock_control and shadows the mode, tuning and reference control fields
`timescale 1ns/1ps
`default_nettype none

module crc_cc_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // register port
  input wire logic [13:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  // oscillators and device state
  input wire logic        clock_in_pin,
  input wire logic        multiplier_clock,
  input wire logic        sleep_active,
  input wire logic        power_up_timer_enable,
  input wire logic        fail_safe_enable,
  input wire logic        watchdog_enable,
  input wire logic        two_speed_enable,
  // outputs watched
  input wire logic        clock_out_pin,
  input wire logic        clock_out_oe,
  input wire logic        multiplier_run,
  input wire logic        multiplier_ref_clock,
  input wire logic        usb_clock,
  input wire logic        slow_rc_enable,
  input wire logic        startup_done,
  input wire logic        refout_port_pin,
  input wire logic        refout_port_oe
);
  // ==========================================================================
  // shadows; hold keeps the edge count unarmed while a source switch settles
  logic [2:0] mode_q;
  logic [7:0] tune_q;
  logic [7:0] ref_q;
  logic [7:0] cnt;
  logic [2:0] hold;
  logic       armed;
  wire logic  cfg_w   = reg_write && reg_addr == crc_pkg::CRC_CONFIG_ADDR;
  wire logic  tune_w  = reg_write && reg_addr == crc_pkg::CRC_TUNE_ADDR;
  wire logic  upset   = cfg_w || tune_w || sleep_active;
  wire logic  ext_src = mode_q == 3'h0 || (mode_q == 3'h1 && tune_q[6]);
  wire logic  need_rc = power_up_timer_enable || fail_safe_enable || watchdog_enable
                        || two_speed_enable || mode_q == 3'h7;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_q <= 3'h0;
      tune_q <= 8'h00;
      ref_q  <= 8'h00;
      cnt    <= 8'h00;
      hold   <= 3'h0;
      armed  <= 1'b0;
    end else begin
      if (cfg_w) mode_q <= reg_wdata[2:0];
      if (tune_w) tune_q <= reg_wdata;
      if (reg_write && reg_addr == crc_pkg::CRC_REF_CTRL_ADDR) ref_q <= reg_wdata;
      if ($changed(clock_out_pin)) cnt <= 8'h00;
      else if (mode_q == 3'h1 ? $changed(multiplier_clock) : $changed(clock_in_pin))
        cnt <= cnt + 8'h01;
      if (upset) hold <= 3'h0;
      else if (hold != 3'h7) hold <= hold + 3'h1;
      if (upset) armed <= 1'b0;
      else if ($changed(clock_out_pin)) armed <= ext_src && hold == 3'h7;
    end
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // output relations
  a_clkout_oe_ext: assert property (clock_out_oe == (mode_q <= 3'h1))
    else $error("clock out enable wrong");
  a_clkout_divide: assert property ($changed(clock_out_pin) && armed
    |-> cnt == 8'h04)
    else $error("clock out divide wrong");
  a_startup_ext: assert property (mode_q <= 3'h1 && $past(mode_q) <= 3'h1 |-> startup_done)
    else $error("start-up wait in external mode");
  a_mult_run_modes: assert property (multiplier_run ==
    (tune_q[6] && mode_q inside {3'h1, 3'h3, 3'h5, 3'h6}))
    else $error("multiplier run wrong");
  a_usb_gated: assert property (!multiplier_run |=> !usb_clock)
    else $error("usb clock moves while off");
  a_mult_ref_gated: assert property (!multiplier_run |=> !multiplier_ref_clock)
    else $error("prescaled clock moves while off");
  a_slow_rc_need: assert property (need_rc |-> slow_rc_enable)
    else $error("slow oscillator off");
  a_refout_oe_bit: assert property (refout_port_oe == ref_q[7])
    else $error("reference enable wrong");
  a_refout_stopped: assert property (!refout_port_oe [*2] |-> !refout_port_pin)
    else $error("ref pin moves while off");
  a_refout_sleep_stop: assert property ((sleep_active && !ref_q[5]) [*3]
    |-> !refout_port_pin)
    else $error("ref pin runs in sleep");
  a_refout_no_runt: assert property ($rose(refout_port_pin) && ref_q[4]
    |=> (refout_port_pin || !refout_port_oe || sleep_active) [*3])
    else $error("runt on ref pin");
endmodule : crc_cc_props

`default_nettype wire

// >>> tb/crc_osc_model.sv
// free-running oscillator levels feeding the clock control block
// assumes half periods of four clocks or more
`timescale 1ns/1ps
`default_nettype none

module crc_osc_model #(
  parameter int EXT_HALF  = 6,
  parameter int FAST_HALF = 5,
  parameter int SLOW_HALF = 7,
  parameter int MULT_HALF = 4
) (
  // bench clock
  input  wire logic clock,
  // oscillator levels
  output logic      clock_in_pin,
  output logic      fast_internal_osc,
  output logic      slow_internal_rc,
  output logic      multiplier_clock
);
  // ==========================================================================
  // one tick count; distinct rates make a wrong source choice visible
  int unsigned tick = 0;
  always @(posedge clock) tick <= tick + 1;
  assign clock_in_pin      = 1'((tick / EXT_HALF) % 2);
  assign fast_internal_osc = 1'((tick / FAST_HALF) % 2);
  assign slow_internal_rc  = 1'((tick / SLOW_HALF) % 2);
  assign multiplier_clock  = 1'((tick / MULT_HALF) % 2);
endmodule : crc_osc_model

`default_nettype wire

// >>> tb/test_clock_source_and_refclk_out.sv
// self-checking bench for the clock source and reference output block
// assumes the oscillator model free-runs and the checker is bound at the foot
`timescale 1ns/1ps
`default_nettype none

module test_clock_source_and_refclk_out;
  // ==========================================================================
  // stimulus, outputs and bookkeeping
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] reg_addr = 14'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        sleep_active = 1'b0;
  logic [3:0]  feat = 4'h0;
  logic [7:0]  reg_rdata;
  logic        o_ext, o_fast, o_slow, o_mult, co, co_oe, m_run;
  logic        m_ref, usb, sys, rc_en, st, ro, ro_oe;
  wire logic [8:0] probe = {usb, o_slow, o_mult, o_fast, o_ext, m_ref, sys, ro, co};
  logic [31:0] lfsr = 32'h2e455f89;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cpu_ratio[4] = '{1, 2, 3, 6};
  localparam logic [13:0] A_REF = crc_pkg::CRC_REF_CTRL_ADDR;
  localparam logic [13:0] A_CFG = crc_pkg::CRC_CONFIG_ADDR;
  localparam logic [13:0] A_TUN = crc_pkg::CRC_TUNE_ADDR;
  localparam logic [13:0] A_OSC = crc_pkg::CRC_OSC_CTRL_ADDR;

  always #4 clock = ~clock;

  crc_osc_model u_osc (.clock(clock), .clock_in_pin(o_ext), .fast_internal_osc(o_fast),
    .slow_internal_rc(o_slow), .multiplier_clock(o_mult));
  crc_clock_control #(.STARTUP_EDGES(8)) DUT (.clock, .rst_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .clock_in_pin(o_ext), .fast_internal_osc(o_fast),
    .slow_internal_rc(o_slow), .multiplier_clock(o_mult), .sleep_active,
    .power_up_timer_enable(feat[0]), .fail_safe_enable(feat[1]), .watchdog_enable(feat[2]),
    .two_speed_enable(feat[3]), .clock_out_pin(co), .clock_out_oe(co_oe),
    .multiplier_run(m_run), .multiplier_ref_clock(m_ref), .usb_clock(usb), .system_clock(sys),
    .slow_rc_enable(rc_en), .startup_done(st), .refout_port_pin(ro), .refout_port_oe(ro_oe));

  // ==========================================================================
  // shared tasks
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [13:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    check(what, reg_rdata, exp);
  endtask : rd_chk
  task automatic ctl(input logic sl, input logic [3:0] f);
    @(posedge clock);
    sleep_active <= sl;
    feat <= f;
  endtask : ctl
  // source edges between output toggles; the first two toggles may be partial
  task automatic measure(input string what, input int o, input int s, input int exp);
    logic po, ps;
    int   t, c, guard;
    po = probe[o];
    ps = probe[s];
    t = 0;
    c = 0;
    guard = 0;
    while (t < 4 && guard < 20000) begin
      @(negedge clock);
      guard++;
      if (probe[s] !== ps) c++;
      if (probe[o] !== po) begin
        if (t >= 2) check(what, c, exp);
        t++;
        c = 0;
      end
      po = probe[o];
      ps = probe[s];
    end
    if (t < 4) check(what, t, 4);
  endtask : measure
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(A_REF, 8'h00, "ref ctrl reset");
    check("ref oe reset", ro_oe, 1'b0);
    check("clock out oe reset", co_oe, 1'b1);
    // random settings land while the output runs
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      wr(A_REF, lfsr[7:0]);
      wr(14'h0010, 8'hff);
      rd_chk(A_REF, lfsr[7:0] & 8'hbf, "ref ctrl readback");
      rd_chk(14'h0010, 8'h00, "unmapped read");
      repeat (40) @(posedge clock);
    end
    wr(A_REF, 8'h00);
    measure("clock out ext", 0, 4, 4);
    for (int f = 0; f < 5; f++) begin
      ctl(1'b0, f < 4 ? 4'(1 << f) : 4'h0);
      @(negedge clock);
      check("slow rc enable", rc_en, 1'(f < 4));
    end
    wr(A_TUN, 8'h40);
    for (int m = 0; m < 8; m++) begin
      wr(A_CFG, 8'(m));
      @(negedge clock);
      check("multiplier run", m_run, 1'(m == 1 || m == 3 || m == 5 || m == 6));
      if (m == 7) check("slow rc selected", rc_en, 1'b1);
    end
    wr(A_CFG, 8'h01);
    measure("clock out mult", 0, 6, 4);
    measure("usb clock", 8, 6, 1);
    for (int p = 0; p < 8; p++) begin
      wr(A_CFG, {2'h0, 3'(p), 3'h5});
      measure("prescaler", 3, 5, p + 1);
    end
    for (int c = 0; c < 4; c++) begin
      wr(A_CFG, {2'(c), 3'h0, 3'h5});
      measure("cpu divider", 2, 6, cpu_ratio[c]);
    end
    wr(A_TUN, 8'h00);
    @(negedge clock);
    check("multiplier off", m_run, 1'b0);
    wr(A_CFG, 8'h04);
    for (int k = 1; k < 8; k++) begin
      wr(A_OSC, {1'b0, 3'(k), 4'h0});
      measure("postscaler", 2, 5, 1 << (7 - k));
    end
    wr(A_OSC, 8'h00);
    measure("slow direct", 2, 7, 1);
    wr(A_OSC, 8'h01);
    measure("postscaler long", 2, 5, 256);
    wr(A_OSC, 8'h70);
    wr(A_REF, 8'h81);
    measure("ref from system", 1, 5, 2);
    wr(A_CFG, 8'h00);
    for (int d = 0; d < 8; d++) begin
      wr(A_REF, 8'h90 | 8'(d));
      measure("ref divider", 1, 4, 1 << d);
    end
    check("ref oe on", ro_oe, 1'b1);
    // sleep without, then with, the sleep-run bit; crystal source in both
    wr(A_REF, 8'h91);
    ctl(1'b1, 4'h0);
    repeat (4) @(negedge clock);
    for (int j = 0; j < 20; j++) begin
      @(negedge clock);
      check("ref stopped in sleep", ro, 1'b0);
    end
    ctl(1'b0, 4'h0);
    @(negedge clock);
    check("no start-up wait", st, 1'b1);
    wr(A_REF, 8'hb1);
    ctl(1'b1, 4'h0);
    measure("ref in sleep", 1, 4, 2);
    ctl(1'b0, 4'h0);
    wr(A_REF, 8'h11);
    repeat (3) @(negedge clock);
    check("ref oe off", ro_oe, 1'b0);
    check("ref pin off", ro, 1'b0);
    summarize();
  end

  // watchdog well past the expected run of about 15k cycles
  initial begin
    repeat (80000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule : test_clock_source_and_refclk_out

bind crc_clock_control crc_cc_props u_props (.clock, .rst_n, .reg_addr, .reg_wdata,
  .reg_write, .clock_in_pin, .multiplier_clock, .sleep_active, .power_up_timer_enable,
  .fail_safe_enable, .watchdog_enable, .two_speed_enable, .clock_out_pin, .clock_out_oe,
  .multiplier_run, .multiplier_ref_clock, .usb_clock, .slow_rc_enable, .startup_done,
  .refout_port_pin, .refout_port_oe);

`default_nettype wire
